// *** hdl/rios_consts.vh ***
`ifndef RIOS_CONSTS_VH
`define RIOS_CONSTS_VH

// Blink timebase
`define RIOS_BLINK_HALF_MS      100
`define RIOS_CLK_MHZ            200
`define RIOS_BLINK_HALF_CYC     (`RIOS_BLINK_HALF_MS * 1000 * `RIOS_CLK_MHZ)
`define RIOS_BLINK_CNT_W        32

// Master unit numbers
`define RIOS_UNIT_W             2
`define RIOS_UNIT_MAX           3
`define RIOS_UNIT_STOP_BIT      1

// Slave selector pin positions
`define RIOS_SEL_W              4
`define RIOS_SEL_UNIT_LSB       0
`define RIOS_SEL_UNIT_MSB       1
`define RIOS_SEL_TERM_BIT       3

// Controller flag vectors: one position per master
`define RIOS_FLAG_W             4

`endif

// *** hdl/rios_blink.v ***
`timescale 1ns/10ps
`default_nettype none
`include "rios_consts.vh"

// Shared blink timebase: toggles phase every half period
module rios_blink #(
    parameter [`RIOS_BLINK_CNT_W-1:0] HALF_CYC = `RIOS_BLINK_HALF_CYC
) (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_ce,
    // Phase
    output reg  o_phase
);

    reg [`RIOS_BLINK_CNT_W-1:0] cnt_q;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q   <= {`RIOS_BLINK_CNT_W{1'b0}};
            o_phase <= 1'b0;
        end
        else if (i_ce)
        begin
            if (cnt_q >= HALF_CYC - 1'b1)
            begin
                cnt_q   <= {`RIOS_BLINK_CNT_W{1'b0}};
                o_phase <= ~o_phase;
            end
            else
            begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/rios_status.v ***
// Overview of operation
// R01: Panel unit activity/fault lamp blinks when normal, steady when error present.
// R02: Test switch held repeats test; pass lamp lit until any error.
// R03: Controller must be in program mode while transmission test runs.
// R04: Panel master terminator lamp lit when active, off once terminator found.
// R05: Panel slave I/O fault lamp on local bus error or misrecognition.
// R06: Panel slave unit from pins 1-2, pin 4 terminator, pin 3 ignored.
// R07: Run output on in run or monitor, off in program or error.
// R08: Master unit 0/1: activity blinks if any remote good, dark otherwise; code also holds it dark on a refresh error.
// R09: Master unit 2/3: activity dark on any remote error or refresh error.
// R10: Master fault lamp lit on any remote error or refresh failure.
// R11: End-unit search lamp lit from start until terminator found.
// R12: Refuse operation on duplicate or undefined master unit number.
// R13: Unit number selects one error flag and one restart flag position.
// R14: Unit 0/1 keeps transmitting after transmission errors.
// R15: Unit 2/3 halts all transmission on a transmission error.
// R16: Slave lamps dark until master system check finished.
// R17: Normal slave exchange: activity blinks, both fault lamps dark.
// R18: Slave link error: activity dark, fault1 lit, fault2 dark, run dark.
// R19: Slave local bus fault: both fault lamps lit, run off.
// R20: Configuration changed: activity blinks, fault1 blinks, fault2 steady.
// R21: Units swapped: activity blinks, both fault lamps lit, run off.
// R22: Expansion rack unverified: activity blinks, fault1 lit, fault2 blinks.
// R23: Blink period is a parameter; one shared blink timebase for all lamps.
`timescale 1ns/10ps
`default_nettype none
`include "rios_consts.vh"

module rios_status #(
    parameter [`RIOS_BLINK_CNT_W-1:0] BLINK_HALF_CYC = `RIOS_BLINK_HALF_CYC
) (
    // Clock, reset, enable
    input  wire                     i_clk,
    input  wire                     i_rst,
    input  wire                     i_ce,
    // Controller state
    input  wire                     i_cpu_run,
    input  wire                     i_cpu_program,
    input  wire                     i_cpu_refresh_err,
    // Chain state
    input  wire                     i_xfer_active,
    input  wire                     i_any_remote_ok,
    input  wire                     i_any_remote_err,
    input  wire                     i_terminator_found,
    // Panel master test
    input  wire                     i_test_switch,
    input  wire                     i_test_result_valid,
    input  wire                     i_test_result_err,
    // Numbered master setting
    input  wire [2:0]               i_master_unit_sel,
    input  wire                     i_unit_dup,
    // Slave conditions
    input  wire                     i_check_done,
    input  wire                     i_link_err,
    input  wire                     i_local_bus_err,
    input  wire                     i_misrecognised,
    input  wire                     i_cfg_changed,
    input  wire                     i_io_swapped,
    input  wire                     i_rack_unverified,
    input  wire [`RIOS_SEL_W-1:0]   i_slave_sel,
    // Panel lamps
    output reg                      o_act_fault_lamp,
    output reg                      o_test_pass_lamp,
    output reg                      o_term_search_lamp,
    output reg                      o_io_fault_lamp,
    output reg                      o_test_refused,
    // Numbered master
    output reg                      o_transfer_activity_lamp,
    output reg                      o_xmit_fault_lamp,
    output reg                      o_end_unit_search_lamp,
    output reg                      o_operate,
    output reg                      o_xmit_enable,
    output reg  [`RIOS_FLAG_W-1:0]  o_err_flags,
    output reg  [`RIOS_FLAG_W-1:0]  o_restart_flags,
    // Numbered slave
    output reg                      o_slave_act_lamp,
    output reg                      o_slave_fault1_lamp,
    output reg                      o_slave_fault2_lamp,
    output reg                      o_slave_run_lamp,
    output reg                      o_run_out,
    output reg  [1:0]               o_slave_unit,
    output reg                      o_slave_terminator
);

    // ------------------------------------------------------------
    // Blink timebase
    // ------------------------------------------------------------
    wire blink;

    rios_blink #(
        .HALF_CYC (BLINK_HALF_CYC)
    ) u_blink (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .o_phase (blink)
    ); // R23

    // Blink when normal, steady when error, dark otherwise
    function lamp_code;
        input act;
        input err;
        input ph;
        begin
            lamp_code = err | (act & ph);
        end
    endfunction

    // ------------------------------------------------------------
    // Run qualifier
    // ------------------------------------------------------------
    // Controller running and not being programmed
    function run_ok;
        input run;
        input prog;
        begin
            run_ok = run & ~prog;
        end
    endfunction

    // ------------------------------------------------------------
    // Unit number decode
    // ------------------------------------------------------------
    wire       unit_valid = (i_master_unit_sel <= `RIOS_UNIT_MAX);
    wire [1:0] unit_num   = i_master_unit_sel[1:0];
    wire       stop_mode  = unit_num[`RIOS_UNIT_STOP_BIT];
    wire       op_ok      = unit_valid & ~i_unit_dup; // R12
    wire       any_err    = i_any_remote_err | i_cpu_refresh_err;

    // ------------------------------------------------------------
    // Sticky state
    // ------------------------------------------------------------
    reg test_fail_q;
    reg test_fail_d;
    reg halted_q;
    reg halted_d;
    reg term_found_q;
    reg term_found_d;

    always @*
    begin
        test_fail_d = test_fail_q;
        if (!i_test_switch)
            test_fail_d = 1'b0;
        else if (i_test_result_valid && i_test_result_err)
            test_fail_d = 1'b1; // R02
        halted_d = halted_q;
        // Halt belongs to stop mode only; a unit moved to 0/1 transmits again
        if (!op_ok || !stop_mode)
            halted_d = 1'b0;
        else if (stop_mode && any_err)
            halted_d = 1'b1; // R15
        term_found_d = term_found_q | i_terminator_found;
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            test_fail_q  <= 1'b0;
            halted_q     <= 1'b0;
            term_found_q <= 1'b0;
        end
        else if (i_ce)
        begin
            test_fail_q  <= test_fail_d;
            halted_q     <= halted_d;
            term_found_q <= term_found_d;
        end
    end

    // ------------------------------------------------------------
    // Slave condition decode, highest severity first
    // ------------------------------------------------------------
    localparam [6:0] SL_OFF    = 7'b000_0001;
    localparam [6:0] SL_NORMAL = 7'b000_0010;
    localparam [6:0] SL_LINK   = 7'b000_0100;
    localparam [6:0] SL_BUS    = 7'b000_1000;
    localparam [6:0] SL_CFG    = 7'b001_0000;
    localparam [6:0] SL_SWAP   = 7'b010_0000;
    localparam [6:0] SL_RACK   = 7'b100_0000;

    reg [6:0] sl_st;

    always @*
    begin
        if (!i_check_done)
            sl_st = SL_OFF;
        else if (i_local_bus_err)
            sl_st = SL_BUS;
        else if (i_link_err)
            sl_st = SL_LINK;
        else if (i_io_swapped)
            sl_st = SL_SWAP;
        else if (i_cfg_changed)
            sl_st = SL_CFG;
        else if (i_rack_unverified)
            sl_st = SL_RACK;
        else
            sl_st = SL_NORMAL;
    end

    reg sl_act;
    reg sl_f1;
    reg sl_f2;
    reg sl_run;

    always @*
    begin
        sl_act = 1'b0;
        sl_f1  = 1'b0;
        sl_f2  = 1'b0;
        sl_run = 1'b0;
        case (sl_st)
            SL_OFF:
            begin
                sl_run = 1'b0; // R16
            end
            SL_NORMAL:
            begin
                sl_act = blink; // R17
                sl_run = run_ok(i_cpu_run, i_cpu_program);
            end
            SL_LINK:
            begin
                sl_f1 = 1'b1; // R18
            end
            SL_BUS:
            begin
                sl_act = i_xfer_active & blink; // R19
                sl_f1  = 1'b1;
                sl_f2  = 1'b1;
            end
            SL_CFG:
            begin
                sl_act = blink; // R20
                sl_f1  = blink;
                sl_f2  = 1'b1;
                sl_run = run_ok(i_cpu_run, i_cpu_program);
            end
            SL_SWAP:
            begin
                sl_act = blink; // R21
                sl_f1  = 1'b1;
                sl_f2  = 1'b1;
            end
            SL_RACK:
            begin
                sl_act = blink; // R22
                sl_f1  = 1'b1;
                sl_f2  = blink;
                sl_run = run_ok(i_cpu_run, i_cpu_program);
            end
            default:
            begin
                sl_run = 1'b0;
            end
        endcase
    end

    wire any_slave_err = i_link_err | i_local_bus_err | i_misrecognised | i_io_swapped;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_act_fault_lamp         <= 1'b0;
            o_test_pass_lamp         <= 1'b0;
            o_term_search_lamp       <= 1'b0;
            o_io_fault_lamp          <= 1'b0;
            o_test_refused           <= 1'b0;
            o_transfer_activity_lamp <= 1'b0;
            o_xmit_fault_lamp        <= 1'b0;
            o_end_unit_search_lamp   <= 1'b0;
            o_operate                <= 1'b0;
            o_xmit_enable            <= 1'b0;
            o_err_flags              <= {`RIOS_FLAG_W{1'b0}};
            o_restart_flags          <= {`RIOS_FLAG_W{1'b0}};
            o_slave_act_lamp         <= 1'b0;
            o_slave_fault1_lamp      <= 1'b0;
            o_slave_fault2_lamp      <= 1'b0;
            o_slave_run_lamp         <= 1'b0;
            o_run_out                <= 1'b0;
            o_slave_unit             <= 2'b00;
            o_slave_terminator       <= 1'b0;
        end
        else if (i_ce)
        begin
            o_act_fault_lamp <= lamp_code(i_xfer_active, any_err | any_slave_err, blink); // R01
            o_test_pass_lamp <= i_test_switch & i_cpu_program & ~test_fail_d; // R02
            o_test_refused   <= i_test_switch & ~i_cpu_program; // R03
            o_term_search_lamp <= ~term_found_d; // R04
            o_io_fault_lamp  <= i_check_done & (i_local_bus_err | i_misrecognised); // R05
            o_operate        <= op_ok;
            o_xmit_fault_lamp <= op_ok & any_err; // R10
            o_end_unit_search_lamp <= op_ok & ~term_found_d; // R11
            // Unit 0/1 keeps sending; unit 2/3 stops once errored
            o_xmit_enable    <= op_ok & ~halted_d; // R14 R15
            if (!op_ok)
                o_transfer_activity_lamp <= 1'b0; // R12
            else if (stop_mode)
                o_transfer_activity_lamp <= ~any_err & ~halted_d & blink; // R09
            else
                o_transfer_activity_lamp <= i_any_remote_ok & ~i_cpu_refresh_err & blink; // R08
            o_err_flags      <= {`RIOS_FLAG_W{1'b0}};
            o_restart_flags  <= {`RIOS_FLAG_W{1'b0}};
            if (op_ok)
            begin
                o_err_flags[unit_num]     <= any_err; // R13
                o_restart_flags[unit_num] <= halted_q & ~any_err; // R13
            end
            o_slave_act_lamp    <= sl_act;
            o_slave_fault1_lamp <= sl_f1;
            o_slave_fault2_lamp <= sl_f2;
            o_slave_run_lamp    <= sl_run;
            o_run_out <= sl_run & ~any_slave_err; // R07
            o_slave_unit <= i_slave_sel[`RIOS_SEL_UNIT_MSB:`RIOS_SEL_UNIT_LSB]; // R06
            o_slave_terminator <= i_slave_sel[`RIOS_SEL_TERM_BIT]; // R06
        end
    end

endmodule
`default_nettype wire

// *** test/rios_status_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module rios_status_props (
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_ce,
    // Inputs watched
    input wire logic       i_cpu_run,
    input wire logic       i_cpu_program,
    input wire logic       i_cpu_refresh_err,
    input wire logic       i_any_remote_ok,
    input wire logic       i_any_remote_err,
    input wire logic       i_terminator_found,
    input wire logic [2:0] i_master_unit_sel,
    input wire logic       i_unit_dup,
    input wire logic       i_check_done,
    input wire logic       i_link_err,
    input wire logic       i_local_bus_err,
    input wire logic       i_misrecognised,
    input wire logic       i_cfg_changed,
    input wire logic       i_io_swapped,
    input wire logic       i_rack_unverified,
    input wire logic [3:0] i_slave_sel,
    // Outputs watched
    input wire logic       o_term_search_lamp,
    input wire logic       o_io_fault_lamp,
    input wire logic       o_test_pass_lamp,
    input wire logic       o_transfer_activity_lamp,
    input wire logic       o_xmit_fault_lamp,
    input wire logic       o_end_unit_search_lamp,
    input wire logic       o_operate,
    input wire logic       o_xmit_enable,
    input wire logic [3:0] o_err_flags,
    input wire logic       o_slave_act_lamp,
    input wire logic       o_slave_fault1_lamp,
    input wire logic       o_slave_fault2_lamp,
    input wire logic       o_slave_run_lamp,
    input wire logic       o_run_out,
    input wire logic [1:0] o_slave_unit,
    input wire logic       o_slave_terminator
);
    // ------------------------------
    // Previous edge was a live load
    // ------------------------------
    logic live_q;
    wire  op = (i_master_unit_sel < 3'h4) && !i_unit_dup;
    wire  hi = i_master_unit_sel[1];
    wire  sl_chk = i_check_done && !i_local_bus_err && !i_link_err;
    always_ff @(posedge i_clk or posedge i_rst)
        if (i_rst)
            live_q <= 1'b0;
        else
            live_q <= i_ce;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    fault_lamp_a: assert property (live_q && $past(op) |-> o_xmit_fault_lamp == $past(i_any_remote_err || i_cpu_refresh_err))
        else $error("transmission fault lamp wrong");
    act_low_a: assert property (live_q && $past(op && !hi && (!i_any_remote_ok || i_cpu_refresh_err)) |-> !o_transfer_activity_lamp)
        else $error("activity lamp lit for low unit");
    act_high_a: assert property (live_q && $past(op && hi && (i_any_remote_err || i_cpu_refresh_err)) |-> !o_transfer_activity_lamp)
        else $error("activity lamp lit for high unit");
    keep_xmit_a: assert property (live_q && $past(op && !hi) |-> o_xmit_enable)
        else $error("low unit stopped transmitting");
    halt_xmit_a: assert property (live_q && $past(op && hi && i_any_remote_err) |-> !o_xmit_enable)
        else $error("high unit kept transmitting");
    refuse_op_a: assert property (live_q && $past(!op) |-> !o_operate && !o_xmit_enable && o_err_flags == 4'h0)
        else $error("operation not refused");
    err_flag_a: assert property (live_q && $past(op && i_any_remote_err) |-> o_err_flags == 4'h1 << $past(i_master_unit_sel[1:0]))
        else $error("error flag position wrong");
    term_dark_a: assert property (live_q && $past(i_terminator_found) |-> !o_end_unit_search_lamp && !o_term_search_lamp)
        else $error("search lamp lit after terminator");
    slave_sel_a: assert property (live_q |-> o_slave_unit == $past(i_slave_sel[1:0]) && o_slave_terminator == $past(i_slave_sel[3]))
        else $error("slave selector decode wrong");
    slave_dark_a: assert property (live_q && $past(!i_check_done) |->
        !(o_slave_act_lamp || o_slave_fault1_lamp || o_slave_fault2_lamp || o_slave_run_lamp))
        else $error("slave lamp lit before check");
    link_err_a: assert property (live_q && $past(i_check_done && !i_local_bus_err && i_link_err)
        |-> !o_slave_act_lamp && o_slave_fault1_lamp && !o_slave_fault2_lamp && !o_slave_run_lamp)
        else $error("link error lamps wrong");
    bus_err_a: assert property (live_q && $past(i_check_done && i_local_bus_err) |-> o_slave_fault1_lamp && o_slave_fault2_lamp && !o_slave_run_lamp)
        else $error("bus error lamps wrong");
    run_out_a: assert property (live_q && $past(i_cpu_program || !i_cpu_run) |-> !o_run_out)
        else $error("run output high while not running");
    io_fault_a: assert property (live_q && $past(i_check_done && (i_local_bus_err || i_misrecognised)) |->
        o_io_fault_lamp)
        else $error("local fault lamp dark");
    normal_dark_a: assert property (live_q && $past(sl_chk && !i_io_swapped && !i_cfg_changed && !i_rack_unverified) |->
        !o_slave_fault1_lamp && !o_slave_fault2_lamp)
        else $error("fault lamp lit in normal exchange");
    swap_lamps_a: assert property (live_q && $past(sl_chk && i_io_swapped) |->
        o_slave_fault1_lamp && o_slave_fault2_lamp && !o_slave_run_lamp)
        else $error("swapped unit lamps wrong");
    cfg_lamps_a: assert property (live_q && $past(sl_chk && !i_io_swapped && i_cfg_changed) |-> o_slave_fault2_lamp)
        else $error("changed configuration lamp wrong");
    rack_lamps_a: assert property (live_q && $past(sl_chk && !i_io_swapped && !i_cfg_changed && i_rack_unverified) |->
        o_slave_fault1_lamp)
        else $error("unverified rack lamp wrong");
    cover property (live_q && o_xmit_fault_lamp && !o_xmit_enable);
    cover property (o_test_pass_lamp);
    cover property (o_slave_fault1_lamp && o_slave_fault2_lamp);
    cover property (live_q && o_slave_fault2_lamp && !o_slave_fault1_lamp);
endmodule
bind rios_status rios_status_props rios_status_props_i (.*);
`default_nettype wire

// *** test/rios_chain_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rios_chain_model #(
    parameter int TERM_DLY = 8
) (
    // Control
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_fail,
    // Chain state
    output logic            o_any_ok,
    output logic            o_any_err,
    output logic            o_term_found,
    output logic            o_xfer_active
);
    int cnt;
    // ------------------------------
    // Terminator answers after delay
    // ------------------------------
    always @(negedge i_clk or posedge i_rst)
        if (i_rst)
            cnt <= 0;
        else if (cnt < TERM_DLY)
            cnt <= cnt + 1;
    // Fail 0 all good, 2 all bad, else one bad
    assign o_term_found  = cnt == TERM_DLY;
    assign o_any_ok      = i_fail != 2'h2;
    assign o_any_err     = i_fail != 2'h0;
    assign o_xfer_active = o_any_ok;
endmodule
`default_nettype wire

// *** test/rios_status_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rios_status_tb;
    // --------
    // Signals
    // --------
    logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_cpu_run = 1'b0, i_cpu_program = 1'b0, i_cpu_refresh_err = 1'b0;
    logic i_test_switch = 1'b0, i_test_result_valid = 1'b0, i_test_result_err = 1'b0, i_unit_dup = 1'b0;
    logic i_check_done = 1'b0, i_link_err = 1'b0, i_local_bus_err = 1'b0, i_misrecognised = 1'b0;
    logic i_cfg_changed = 1'b0, i_io_swapped = 1'b0, i_rack_unverified = 1'b0;
    logic [2:0] i_master_unit_sel = 3'h0;
    logic [3:0] i_slave_sel = 4'h0;
    logic [1:0] fail = 2'h0;
    wire i_xfer_active, i_any_remote_ok, i_any_remote_err, i_terminator_found;
    wire o_act_fault_lamp, o_test_pass_lamp, o_term_search_lamp, o_io_fault_lamp, o_test_refused;
    wire o_transfer_activity_lamp, o_xmit_fault_lamp, o_end_unit_search_lamp, o_operate, o_xmit_enable;
    wire o_slave_act_lamp, o_slave_fault1_lamp, o_slave_fault2_lamp, o_slave_run_lamp, o_run_out, o_slave_terminator;
    wire [3:0] o_err_flags, o_restart_flags;
    wire [1:0] o_slave_unit;
    integer seed = 32'hea51;
    int miscompares = 0, samples_checked = 0, cycles = 0, ta, tb;
    rios_status #(.BLINK_HALF_CYC(32'h0000_0004)) rios_status_i (.*);
    rios_chain_model #(.TERM_DLY(8)) rios_chain_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_fail(fail),
        .o_any_ok(i_any_remote_ok), .o_any_err(i_any_remote_err), .o_term_found(i_terminator_found),
        .o_xfer_active(i_xfer_active));
    always #2.5 i_clk = ~i_clk;
    // --------
    // Helpers
    // --------
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected {local fault lamp, run output} for the inputs now applied
    function automatic logic [1:0] exp_slave();
        exp_slave[1] = i_check_done && (i_local_bus_err || i_misrecognised);
        exp_slave[0] = i_check_done && i_cpu_run && !i_cpu_program && !i_link_err && !i_local_bus_err
            && !i_misrecognised && !i_io_swapped;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic blink(input int n);
        logic a, b;
        ta = 0;
        tb = 0;
        a = o_transfer_activity_lamp;
        b = o_act_fault_lamp;
        repeat (n)
        begin
            @(negedge i_clk);
            ta += int'(o_transfer_activity_lamp !== a);
            tb += int'(o_act_fault_lamp !== b);
            a = o_transfer_activity_lamp;
            b = o_act_fault_lamp;
        end
    endtask
    task automatic result(input logic err);
        i_test_result_err = err;
        i_test_result_valid = 1'b1;
        cyc(1);
        i_test_result_valid = 1'b0;
        cyc(2);
    endtask
    task automatic tally_and_finish;
        $display("Summary: %0d checks, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end
    // ---------
    // Sequence
    // ---------
    initial
    begin
        repeat (6) @(posedge i_clk);
        cyc(1);
        i_rst = 1'b0;
        cyc(2);
        chk(o_end_unit_search_lamp, 1'b1);
        chk(o_term_search_lamp, 1'b1);
        cyc(10);
        chk(o_end_unit_search_lamp, 1'b0);
        chk(o_term_search_lamp, 1'b0);
        $display("Test terminator search done");
        fail = 2'h1;
        for (int s = 0; s < 4; s++)
        begin
            i_unit_dup = 1'b1;
            cyc(1);
            i_unit_dup = 1'b0;
            i_master_unit_sel = s[2:0];
            cyc(2);
            chk(o_err_flags, 4'h1 << s);
            chk(o_xmit_enable, !s[1]);
            chk(o_xmit_fault_lamp, 1'b1);
        end
        fail = 2'h0;
        cyc(2);
        chk(o_xmit_enable, 1'b0);
        chk(o_restart_flags, 4'h8);
        $display("Test unit policy done");
        i_unit_dup = 1'b1;
        cyc(1);
        i_unit_dup = 1'b0;
        i_master_unit_sel = 3'h0;
        cyc(2);
        blink(40);
        chk(ta >= 9 && ta <= 11, 1'b1);
        chk(tb >= 9 && tb <= 11, 1'b1);
        fail = 2'h2;
        cyc(2);
        blink(20);
        chk({ta == 0, o_transfer_activity_lamp}, 2'b10);
        chk({tb == 0, o_act_fault_lamp}, 2'b11);
        $display("Test blink done");
        fail = 2'h0;
        i_test_switch = 1'b1;
        cyc(2);
        chk(o_test_refused, 1'b1);
        i_cpu_program = 1'b1;
        result(1'b0);
        chk(o_test_pass_lamp, 1'b1);
        result(1'b1);
        chk(o_test_pass_lamp, 1'b0);
        result(1'b0);
        chk(o_test_pass_lamp, 1'b0);
        i_test_switch = 1'b0;
        $display("Test transmission test done");
        for (int k = 0; k < 800; k++)
        begin
            {i_ce, i_cpu_run, i_cpu_program, i_cpu_refresh_err, i_test_switch, i_test_result_valid,
                i_test_result_err, i_unit_dup, i_check_done, i_link_err, i_local_bus_err, i_misrecognised,
                i_cfg_changed, i_io_swapped, i_rack_unverified} = 15'($random(seed));
            {i_master_unit_sel, i_slave_sel, fail} = 9'($random(seed));
            i_rst = (k == 400);
            cyc(1);
            if (i_ce && !i_rst)
            begin
                chk(o_operate, i_master_unit_sel < 3'h4 && !i_unit_dup);
                chk({o_io_fault_lamp, o_run_out}, exp_slave());
            end
        end
        $display("Test random traffic done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
